// ===== hw/tbp_channel.sv
// Ten-bit PWM channel with its period timer and AXI4-Lite register slave.
// How it works
// R1: Duty is ten bits: high register holds 9:2, low register bits 7:6 hold 1:0.
// R2: Timer count equal to period limit clears on the next increment cycle.
// R3: Rollover drives output active for a nonzero software duty within the period, inactive for zero.
// R4: Rollover copies software duty into the compare buffer for the next period.
// R5: Duty writes any time; they only take effect at the period match.
// R6: Time base is timer count joined with quarter-cycle or prescaler top bits.
// R7: Output goes inactive when the time base reaches the buffered duty.
// R8: Period equals limit plus one, times four clocks, times prescale.
// R9: Duty beyond period leaves output unchanged at rollover, no compare clear.
// R10: Idle level is the polarity bit; disabled channel drives idle.
// R11: Control bit 7 enables the channel.
// R12: Control bit 5 reads back the present output level.
// R13: Sleep stops the timer and freezes the duty buffer and the output level register.
// R14: Reset returns registers to reset values and turns the pin driver off.
// R15: Resolution is log2 of four times limit plus one, ten bits at 255.
// R16: Pin is driven only while the pin direction bit is clear.
// R17: Software follows the set-up order for a complete first period.
// R18: Enabling before the timer runs is tolerated.
// R19: A two-bit selector picks one of three timers; 00 is reserved.
`timescale 1ns/1ps
`default_nettype none
module tbp_channel (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic sleep_req, // High while the device sleeps.
    input wire logic pin_direction_bit, // Set means pin is an input.
    input wire logic [7:0] ext_timer_b_count, // Count of the second timer.
    input wire logic ext_timer_b_match, // Second timer period match, one cycle early.
    input wire logic [1:0] ext_timer_b_low, // Second timer low time-base bits.
    input wire logic [7:0] ext_timer_c_count, // Count of the third timer.
    input wire logic ext_timer_c_match, // Third timer period match.
    input wire logic [1:0] ext_timer_c_low, // Third timer low time-base bits.
    output logic pwm_out, // Pin output value.
    output logic pwm_oe, // Pin output enable, high when driving.
    input wire logic [7:0] s_axi_awaddr, // Write address.
    input wire logic s_axi_awvalid, // Write address valid.
    output logic s_axi_awready, // Write address ready.
    input wire logic [31:0] s_axi_wdata, // Write data.
    input wire logic [3:0] s_axi_wstrb, // Write strobes.
    input wire logic s_axi_wvalid, // Write data valid.
    output logic s_axi_wready, // Write data ready.
    output logic [1:0] s_axi_bresp, // Write response.
    output logic s_axi_bvalid, // Write response valid.
    input wire logic s_axi_bready, // Write response ready.
    input wire logic [7:0] s_axi_araddr, // Read address.
    input wire logic s_axi_arvalid, // Read address valid.
    output logic s_axi_arready, // Read address ready.
    output logic [31:0] s_axi_rdata, // Read data.
    output logic [1:0] s_axi_rresp, // Read response.
    output logic s_axi_rvalid, // Read response valid.
    input wire logic s_axi_rready // Read response ready.
);
    logic enable_r, polarity_r, level_r;
    logic [7:0] duty_high_r;
    logic [1:0] duty_low_r;
    logic [9:0] duty_buf_r;
    logic [7:0] period_limit_r, timer_count_r;
    logic [1:0] prescale_sel_r, sel_r;
    logic run_r, flag_r;
    logic [1:0] quarter_r;
    logic sleep_s1_r, sleep_s2_r, sleep_s3_r;
    logic dir_s1_r, dir_s2_r, dir_s3_r, dir_r;
    logic [7:0] awaddr_r, araddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_got_r, w_got_r;

    // Pin inputs cross through three flops; a change is accepted once the last two agree.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sleep_s1_r <= 1'b0;
            sleep_s2_r <= 1'b0;
            sleep_s3_r <= 1'b0;
            dir_s1_r <= 1'b1;
            dir_s2_r <= 1'b1;
            dir_s3_r <= 1'b1;
            dir_r <= 1'b1;
        end else begin
            sleep_s1_r <= sleep_req;
            sleep_s2_r <= sleep_s1_r;
            sleep_s3_r <= sleep_s2_r;
            dir_s1_r <= pin_direction_bit;
            dir_s2_r <= dir_s1_r;
            dir_s3_r <= dir_s2_r;
            if (dir_s2_r == dir_s3_r) begin
                dir_r <= dir_s3_r;
            end
        end
    end

    logic asleep_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            asleep_r <= 1'b0;
        end else if (sleep_s2_r == sleep_s3_r) begin
            asleep_r <= sleep_s3_r;
        end
    end

    // Prescale 1, 4, 16, 64; above prescale 1 the low two bits of the time base come from here.
    logic [3:0] presc_top;
    always_comb begin
        case (prescale_sel_r)
            2'h0: presc_top = 4'h0;
            2'h1: presc_top = 4'h3;
            default: presc_top = 4'hf;
        endcase
    end
    logic [5:0] presc_wide_r;
    logic [5:0] presc_wide_top;
    assign presc_wide_top = (prescale_sel_r == 2'h3) ? 6'h3f : {2'h0, presc_top};
    logic tick;
    // A timer increment happens each time the quarter counter and prescaler both wrap.
    // Compare with >= so that a prescale lowered mid-count wraps at once instead of running the counter round.
    assign tick = run_r && !asleep_r && (quarter_r == 2'h3) && (presc_wide_r >= presc_wide_top);
    logic own_match;
    assign own_match = tick && (timer_count_r == period_limit_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            quarter_r <= 2'h0;
            presc_wide_r <= 6'h00;
            timer_count_r <= 8'h00;
        end else if (run_r && !asleep_r) begin // R13
            quarter_r <= quarter_r + 2'h1;
            if (quarter_r == 2'h3) begin
                presc_wide_r <= (presc_wide_r >= presc_wide_top) ? 6'h00 : presc_wide_r + 6'h01;
            end
            if (own_match) begin
                timer_count_r <= 8'h00; // R2 R8
            end else if (tick) begin
                timer_count_r <= timer_count_r + 8'h01;
            end
        end
    end
    // Time base selection across the three timers.
    logic [7:0] sel_count;
    logic [1:0] sel_low;
    logic sel_match;
    logic [1:0] own_low;
    // The two fraction bits are the quarter counter at prescale 1, else the top two bits of the prescaler, so each step lasts one prescale.
    always_comb begin
        case (prescale_sel_r) // R6
            2'h0: own_low = quarter_r;
            2'h1: own_low = presc_wide_r[1:0];
            2'h2: own_low = presc_wide_r[3:2];
            default: own_low = presc_wide_r[5:4];
        endcase
    end
    always_comb begin
        case (sel_r) // R19
            tbp_pkg::SEL_TIMER_B: begin
                sel_count = ext_timer_b_count;
                sel_low = ext_timer_b_low;
                sel_match = ext_timer_b_match;
            end
            tbp_pkg::SEL_TIMER_C: begin
                sel_count = ext_timer_c_count;
                sel_low = ext_timer_c_low;
                sel_match = ext_timer_c_match;
            end
            tbp_pkg::SEL_TIMER_A: begin
                sel_count = timer_count_r;
                sel_low = own_low;
                sel_match = own_match;
            end
            default: begin
                sel_count = 8'h00;
                sel_low = 2'h0;
                sel_match = 1'b0;
            end
        endcase
    end
    logic [9:0] timebase;
    assign timebase = {sel_count, sel_low}; // R6 R15

    // Waveform: set at rollover, clear at compare; both suppressed in sleep.
    logic [9:0] duty_sw;
    assign duty_sw = {duty_high_r, duty_low_r}; // R1
    logic [9:0] period_len;
    assign period_len = {period_limit_r, 2'h3};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            duty_buf_r <= 10'h000;
            level_r <= 1'b0;
        end else if (!asleep_r) begin // R13
            if (sel_match) begin
                duty_buf_r <= duty_sw; // R4 R5
                if (duty_sw != 10'h000 && duty_sw <= period_len) begin
                    level_r <= 1'b1; // R3 R9
                end else if (duty_sw == 10'h000) begin
                    level_r <= 1'b0; // R3
                end
            end else if (timebase == duty_buf_r && duty_buf_r <= period_len) begin
                level_r <= 1'b0; // R7 R9
            end
        end
    end

    // The compare hit masks the level in its first step, so the pulse lasts exactly duty steps.
    logic wave_level;
    assign wave_level = level_r && (timebase != duty_buf_r); // R7
    logic pin_level;
    assign pin_level = enable_r ? (wave_level ^ polarity_r) : polarity_r; // R10 R11 R18
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_out <= 1'b0;
            pwm_oe <= 1'b0; // R14
        end else begin
            pwm_out <= pin_level;
            pwm_oe <= !dir_r; // R16
        end
    end

    // AXI4-Lite slave; address and data latched in either order.
    logic wr_fire;
    assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
    logic wr_mapped;
    assign wr_mapped = (awaddr_r <= tbp_pkg::ADDR_TIMEBASE_SEL) && (awaddr_r[1:0] == 2'h0);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r <= 1'b0;
            w_got_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= tbp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_got_r <= 1'b0;
                w_got_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_mapped ? tbp_pkg::RESP_OKAY : tbp_pkg::RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
    assign s_axi_wready = !w_got_r && !s_axi_bvalid;

    logic wr_lane0;
    assign wr_lane0 = wr_fire && wstrb_r[0];
    // Timer match flag: set by the timer, cleared by writing 0; set wins.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flag_r <= 1'b0;
        end else if (own_match) begin
            flag_r <= 1'b1;
        end else if (wr_lane0 && awaddr_r == tbp_pkg::ADDR_TIMER_CONTROL && !wdata_r[tbp_pkg::TCTL_FLAG_BIT]) begin
            flag_r <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            enable_r <= 1'b0;
            polarity_r <= 1'b0;
            duty_high_r <= 8'h00;
            duty_low_r <= 2'h0;
            period_limit_r <= tbp_pkg::PERIOD_RESET;
            prescale_sel_r <= 2'h0;
            run_r <= 1'b0;
            sel_r <= tbp_pkg::SEL_RESET; // R14
        end else if (wr_lane0) begin
            case (awaddr_r)
                tbp_pkg::ADDR_CONTROL: begin
                    enable_r <= wdata_r[tbp_pkg::CTL_ENABLE_BIT]; // R11
                    polarity_r <= wdata_r[tbp_pkg::CTL_POL_BIT]; // R10
                end
                tbp_pkg::ADDR_DUTY_HIGH: duty_high_r <= wdata_r[7:0]; // R1 R5
                tbp_pkg::ADDR_DUTY_LOW: duty_low_r <= wdata_r[7:6]; // R1
                tbp_pkg::ADDR_TIMER_CONTROL: begin
                    run_r <= wdata_r[tbp_pkg::TCTL_RUN_BIT];
                    prescale_sel_r <= wdata_r[1:0];
                end
                tbp_pkg::ADDR_PERIOD_LIMIT: period_limit_r <= wdata_r[7:0];
                tbp_pkg::ADDR_TIMEBASE_SEL: sel_r <= wdata_r[1:0]; // R19
                default: ;
            endcase
        end
    end

    logic [7:0] rd_value;
    always_comb begin
        case (araddr_r)
            tbp_pkg::ADDR_CONTROL: rd_value = {enable_r, 1'b0, pin_level, polarity_r, 4'h0}; // R12
            tbp_pkg::ADDR_DUTY_HIGH: rd_value = duty_high_r;
            tbp_pkg::ADDR_DUTY_LOW: rd_value = {duty_low_r, 6'h00};
            tbp_pkg::ADDR_TIMER_CONTROL: rd_value = {flag_r, 4'h0, run_r, prescale_sel_r};
            tbp_pkg::ADDR_PERIOD_LIMIT: rd_value = period_limit_r;
            tbp_pkg::ADDR_TIMER_COUNT: rd_value = timer_count_r;
            tbp_pkg::ADDR_TIMEBASE_SEL: rd_value = {6'h00, sel_r};
            default: rd_value = 8'h00;
        endcase
    end
    logic rd_mapped;
    assign rd_mapped = (araddr_r <= tbp_pkg::ADDR_TIMEBASE_SEL) && (araddr_r[1:0] == 2'h0);
    logic ar_got_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_got_r <= 1'b0;
            araddr_r <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= tbp_pkg::RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                ar_got_r <= 1'b1;
                araddr_r <= s_axi_araddr;
            end
            if (ar_got_r && !s_axi_rvalid) begin
                ar_got_r <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= {24'h000000, rd_value};
                s_axi_rresp <= rd_mapped ? tbp_pkg::RESP_OKAY : tbp_pkg::RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
    assign s_axi_arready = !ar_got_r && !s_axi_rvalid;

    a_enable_idle: assert property (@(posedge aclk) disable iff (!aresetn)
        !enable_r |=> pwm_out == $past(polarity_r)) else $error("disabled channel not idle"); // R10
    a_driver_off: assert property (@(posedge aclk) disable iff (!aresetn)
        dir_r |=> !pwm_oe) else $error("pin driven while direction is input"); // R16
    a_sleep_freeze: assert property (@(posedge aclk) disable iff (!aresetn)
        asleep_r |=> $stable(timer_count_r) && $stable(level_r)) else $error("state moved in sleep"); // R13
    a_timer_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
        own_match |=> timer_count_r == 8'h00) else $error("timer not cleared at limit"); // R2
    a_duty_latch: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_match && !asleep_r |=> duty_buf_r == $past(duty_sw)) else $error("duty not latched"); // R4
    a_zero_duty: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_match && !asleep_r && duty_sw == 10'h000 |=> !level_r) else $error("zero duty set output"); // R3
    a_set_active: assert property (@(posedge aclk) disable iff (!aresetn)
        sel_match && !asleep_r && duty_sw != 10'h000 && duty_sw <= period_len |=> level_r)
        else $error("rollover did not set output"); // R3
    a_hold_buffer: assert property (@(posedge aclk) disable iff (!aresetn)
        !sel_match |=> $stable(duty_buf_r)) else $error("duty buffer changed mid period"); // R5
endmodule
`default_nettype wire

// ===== hw/tbp_pkg.sv
// Constants for the ten-bit PWM channel: register map, field positions, reset values.
package tbp_pkg;
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_DUTY_HIGH = 8'h04;
    localparam logic [7:0] ADDR_DUTY_LOW = 8'h08;
    localparam logic [7:0] ADDR_TIMER_CONTROL = 8'h0c;
    localparam logic [7:0] ADDR_PERIOD_LIMIT = 8'h10;
    localparam logic [7:0] ADDR_TIMER_COUNT = 8'h14;
    localparam logic [7:0] ADDR_TIMEBASE_SEL = 8'h18;
    localparam int CTL_ENABLE_BIT = 7;
    localparam int CTL_OUT_BIT = 5;
    localparam int CTL_POL_BIT = 4;
    localparam int TCTL_FLAG_BIT = 7;
    localparam int TCTL_RUN_BIT = 2;
    localparam logic [1:0] SEL_RESERVED = 2'h0;
    localparam logic [1:0] SEL_TIMER_A = 2'h1;
    localparam logic [1:0] SEL_TIMER_B = 2'h2;
    localparam logic [1:0] SEL_TIMER_C = 2'h3;
    localparam logic [1:0] SEL_RESET = 2'h1;
    localparam logic [7:0] PERIOD_RESET = 8'hff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ===== test/tbp_load_model.sv
// Load on the channel pin: resolves the pin level and measures pulse and period lengths.
`timescale 1ns/1ps
`default_nettype none
module tbp_load_model (
    input wire logic aclk, // System clock.
    input wire logic aresetn, // Synchronous reset, active low.
    input wire logic pwm_out, // Channel pin value.
    input wire logic pwm_oe, // Channel pin drive enable.
    output logic pin, // Level seen by the load.
    output var int hi_len, // High cycles of the last whole period.
    output var int per_len, // Cycles between the last two rising edges.
    output var int n_rise // Rising edges seen.
);
    logic prev_r;
    int hi_cnt;
    int per_cnt;
    // The load pulls the pin low when nothing drives it, so a released pin never shows a stale level.
    assign pin = pwm_oe ? pwm_out : 1'b0;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_r <= 1'b0;
            hi_cnt <= 0;
            per_cnt <= 0;
            hi_len <= 0;
            per_len <= 0;
            n_rise <= 0;
        end else begin
            prev_r <= pin;
            if (pin && !prev_r) begin
                hi_len <= hi_cnt;
                per_len <= per_cnt;
                n_rise <= n_rise + 1;
                hi_cnt <= 1;
                per_cnt <= 1;
            end else begin
                hi_cnt <= hi_cnt + (pin ? 1 : 0);
                per_cnt <= per_cnt + 1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== test/ten_bit_pwm_channel_test.sv
// Self-checking bench for the ten-bit PWM channel.
`timescale 1ns/1ps
`default_nettype none
module ten_bit_pwm_channel_test;
    logic aclk, aresetn, sleep_req, pin_direction_bit, pwm_out, pwm_oe, pin;
    logic [7:0] ext_cnt;
    logic [1:0] ext_low;
    logic ext_match;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv, rv2;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int hi_len, per_len, n_rise, n_mismatch, checks, cyc, k;
    tbp_channel i_dut (.aclk, .aresetn, .sleep_req, .pin_direction_bit,
        .ext_timer_b_count(ext_cnt), .ext_timer_b_match(ext_match), .ext_timer_b_low(ext_low),
        .ext_timer_c_count(ext_cnt), .ext_timer_c_match(ext_match), .ext_timer_c_low(ext_low),
        .pwm_out, .pwm_oe, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    tbp_load_model i_load (.aclk, .aresetn, .pwm_out, .pwm_oe, .pin, .hi_len, .per_len, .n_rise);
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    // A small stand-in for the other timers, period of four counts.
    assign ext_match = (ext_cnt == 8'h03) && (ext_low == 2'h3);
    always @(posedge aclk) begin
        ext_low <= ext_low + 2'h1;
        if (ext_low == 2'h3)
            ext_cnt <= (ext_cnt == 8'h03) ? 8'h00 : ext_cnt + 8'h01;
    end
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_mismatch++;
            end_sim();
        end
    end
    task automatic end_sim;
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                chk({30'h0, s_axi_bresp}, {30'h0, tbp_pkg::RESP_OKAY}, "write response");
                s_axi_bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic set_duty(input logic [9:0] d);
        wr(tbp_pkg::ADDR_DUTY_HIGH, {24'h0, d[9:2]});
        wr(tbp_pkg::ADDR_DUTY_LOW, {24'h0, d[1:0], 6'h00});
    endtask
    task automatic wait_rise(input int n);
        k = n_rise + n;
        while (n_rise < k) @(posedge aclk);
    endtask
    task automatic t_reset;
        logic [7:0] adr [5] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18};
        logic [7:0] exp [5] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h01};
        chk({30'h0, pwm_out, pwm_oe}, 32'h0, "pin after reset");
        for (int i = 0; i < 5; i++) begin
            rd(adr[i], rv, rr);
            chk(rv, {24'h0, exp[i]}, "reset value");
        end
        rd(8'h1c, rv, rr);
        chk({30'h0, rr}, {30'h0, tbp_pkg::RESP_SLVERR}, "unmapped read response");
        chk(rv, 32'h0, "unmapped read data");
    endtask
    task automatic t_setup;
        wr(tbp_pkg::ADDR_CONTROL, 32'h00);
        wr(tbp_pkg::ADDR_PERIOD_LIMIT, 32'h03);
        set_duty(10'd6);
        wr(tbp_pkg::ADDR_TIMER_CONTROL, 32'h00);
        wr(tbp_pkg::ADDR_TIMER_CONTROL, 32'h04);
        rv = 32'h0;
        while (rv[tbp_pkg::TCTL_FLAG_BIT] !== 1'b1) rd(tbp_pkg::ADDR_TIMER_CONTROL, rv, rr);
        pin_direction_bit <= 1'b0;
        wr(tbp_pkg::ADDR_CONTROL, 32'h80);
        wait_rise(3);
        chk(per_len, 16, "period");
        chk(hi_len, 6, "pulse width");
        chk({31'h0, pwm_oe}, 32'h1, "pin driven");
    endtask
    task automatic t_prescale;
        for (int c = 0; c < 4; c++) begin
            wr(tbp_pkg::ADDR_TIMER_CONTROL, 32'h04 | c);
            wait_rise(3);
            chk(per_len, 16 << (2 * c), "scaled period");
            chk(hi_len, 6 << (2 * c), "scaled width");
        end
        wr(tbp_pkg::ADDR_TIMER_CONTROL, 32'h04);
    endtask
    task automatic t_update;
        set_duty(10'd10);
        wait_rise(2);
        chk(hi_len, 10, "new width");
        wait_rise(1);
        set_duty(10'd2);
        wait_rise(1);
        chk(hi_len, 10, "width held within period");
        wait_rise(1);
        chk(hi_len, 2, "width after rollover");
    endtask
    task automatic t_extremes;
        set_duty(10'd0);
        repeat (40) @(posedge aclk);
        chk({31'h0, pin}, 32'h0, "zero duty");
        rd(tbp_pkg::ADDR_CONTROL, rv, rr);
        chk({31'h0, rv[tbp_pkg::CTL_OUT_BIT]}, 32'h0, "readback low");
        k = n_rise;
        set_duty(10'd16);
        repeat (40) @(posedge aclk);
        chk({n_rise, 31'h0, pin}, {k, 32'h0}, "duty beyond period");
    endtask
    task automatic t_sleep;
        set_duty(10'd6);
        wr(tbp_pkg::ADDR_TIMER_CONTROL, 32'h07);
        wait_rise(1);
        sleep_req <= 1'b1;
        repeat (10) @(posedge aclk);
        rd(tbp_pkg::ADDR_TIMER_COUNT, rv, rr);
        repeat (400) @(posedge aclk);
        rd(tbp_pkg::ADDR_TIMER_COUNT, rv2, rr);
        chk(rv2, rv, "timer frozen");
        chk({31'h0, pin}, 32'h1, "level held");
        rd(tbp_pkg::ADDR_CONTROL, rv, rr);
        chk({31'h0, rv[tbp_pkg::CTL_OUT_BIT]}, 32'h1, "readback high");
        sleep_req <= 1'b0;
        wr(tbp_pkg::ADDR_TIMER_CONTROL, 32'h04);
    endtask
    task automatic t_idle;
        wr(tbp_pkg::ADDR_CONTROL, 32'h00);
        repeat (10) @(posedge aclk);
        chk({31'h0, pwm_out}, 32'h0, "idle low");
        wr(tbp_pkg::ADDR_CONTROL, 32'h10);
        repeat (10) @(posedge aclk);
        chk({31'h0, pwm_out}, 32'h1, "idle high");
        wr(tbp_pkg::ADDR_CONTROL, 32'h90);
        wait_rise(3);
        chk(hi_len, 10, "inverted width");
        pin_direction_bit <= 1'b1;
        repeat (8) @(posedge aclk);
        chk({31'h0, pwm_oe}, 32'h0, "driver off");
        pin_direction_bit <= 1'b0;
        wr(tbp_pkg::ADDR_CONTROL, 32'h80);
    endtask
    task automatic t_select;
        for (int s = 3; s >= 0; s--) begin
            wr(tbp_pkg::ADDR_TIMEBASE_SEL, s);
            rd(tbp_pkg::ADDR_TIMEBASE_SEL, rv, rr);
            chk(rv, s, "selector");
            k = n_rise;
            repeat (64) @(posedge aclk);
        end
        chk(n_rise, k, "reserved selector");
        wr(tbp_pkg::ADDR_TIMEBASE_SEL, 32'h1);
    endtask
    initial begin
        {aresetn, sleep_req, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, ext_cnt, ext_low} = '0;
        s_axi_wstrb = 4'hf;
        pin_direction_bit = 1'b1;
        {n_mismatch, checks, cyc} = '0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_setup();
        t_prescale();
        t_update();
        t_extremes();
        t_sleep();
        t_idle();
        t_select();
        end_sim();
    end
endmodule
`default_nettype wire
